/* File: uhpc_map.svh */
// Register offsets, field positions and reset values of the host port block
`ifndef UHPC_MAP_SVH
`define UHPC_MAP_SVH

`define UHPC_OFS_ASYNC_PTR   8'h28
`define UHPC_OFS_PORT_SC     8'h30
`define UHPC_OFS_IRQ_STAT    8'h40
`define UHPC_OFS_IRQ_MASK    8'h44

`define UHPC_PTR_MASK        32'hFFFF_FFE0
`define UHPC_PTR_RST         32'h0000_0000

`define UHPC_PSC_CONN        0
`define UHPC_PSC_CONN_CHG    1
`define UHPC_PSC_EN          2
`define UHPC_PSC_RESUME      6
`define UHPC_PSC_SUSP        7
`define UHPC_PSC_RST         8
`define UHPC_PSC_LINE_LO     10
`define UHPC_PSC_LINE_HI     11
`define UHPC_PSC_TFORCE      16

`define UHPC_IRQ_W           3
`define UHPC_IRQ_CONN        0
`define UHPC_IRQ_PCD         1
`define UHPC_IRQ_RST_DONE    2
`define UHPC_IRQ_RST         3'h0

`define UHPC_LINE_SE0        2'h0
`define UHPC_LINE_J          2'h2
`define UHPC_LINE_K          2'h1

`endif

/* File: uhpc_pkg.sv */
// Types shared by the host port block
package uhpc_pkg;

  typedef enum logic [1:0] {
    UHPC_PORT_DISABLED,
    UHPC_PORT_ENABLED,
    UHPC_PORT_SUSPENDED
  } uhpc_port_mode_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } uhpc_ahb_req_t;

endpackage : uhpc_pkg

/* File: uhpc_line_mon.sv */
// Bus line level capture and J-to-K detection
`timescale 1ns/1ps
`default_nettype none
`include "uhpc_map.svh"

module uhpc_line_mon (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Bus lines
  input  wire logic       usb_dp,
  input  wire logic       usb_dm,
  // Decoded state
  output logic [1:0]      bus_line_levels,
  output logic            j_to_k
);

  logic [1:0] line_q;
  logic [1:0] prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_q <= `UHPC_LINE_SE0;
      prev_q <= `UHPC_LINE_SE0;
    end else begin
      line_q <= {usb_dp, usb_dm};
      prev_q <= line_q;
    end
  end

  assign bus_line_levels = line_q;
  assign j_to_k          = (prev_q == `UHPC_LINE_J) && (line_q == `UHPC_LINE_K);

  a_line_follows: assert property (@(posedge hclk) disable iff (!hresetn)  // see [R8]
    ##1 bus_line_levels == $past({usb_dp, usb_dm}))
    else $error("line levels do not follow D+ and D-");

endmodule : uhpc_line_mon
`default_nettype wire

/* File: uhpc_port_ctrl.sv */
// Host port control: schedule pointer, root port register and AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "uhpc_map.svh"

// Summary of operation
// [R1] Pointer keeps bits 31:5, low bits zero
// [R2] Port register cleared only by resets
// [R3] After reset: disconnected and disabled
// [R4] Software waits for stable port power
// [R5] Attach sets connected and change flag
// [R6] Test force bit enables port high-speed
// [R7] Software sets run after test force
// [R8] Line field mirrors D+ and D- levels
// [R9] Writing reset one starts bus reset
// [R10] Writing reset zero ends bus reset
// [R11] Software waits 200us after high-speed reset
// [R12] Software stops schedule before port reset
// [R13] Enable and suspend bits give port state
// [R14] Suspend blocks downstream data except reset
// [R15] Suspended port watches for resume
// [R16] Writing suspend zero is ignored
// [R17] J-to-K in suspend sets resume, change
// [R18] Reserved bits ignore writes, read zero
module uhpc_port_ctrl
  import uhpc_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hc_reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Downstream port
  input  wire logic        usb_dp,
  input  wire logic        usb_dm,
  input  wire logic        dev_attached,
  output logic             port_enabled,
  output logic             port_suspended,
  output logic             bus_reset_drive,
  output logic             resume_drive,
  output logic             hs_test_mode,
  output logic             tx_permit,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  uhpc_ahb_req_t req_q;
  logic [31:0]   hrdata_q;
  logic          addr_phase;
  logic          wr_ptr;
  logic          wr_port;
  logic          wr_stat;
  logic          wr_mask;

  assign addr_phase = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else if (hready) begin
      req_q.valid <= addr_phase;
      req_q.write <= hwrite;
      req_q.addr  <= haddr[7:0];
    end
  end

  assign wr_ptr  = req_q.valid && req_q.write && (req_q.addr == `UHPC_OFS_ASYNC_PTR);
  assign wr_port = req_q.valid && req_q.write && (req_q.addr == `UHPC_OFS_PORT_SC);
  assign wr_stat = req_q.valid && req_q.write && (req_q.addr == `UHPC_OFS_IRQ_STAT);
  assign wr_mask = req_q.valid && req_q.write && (req_q.addr == `UHPC_OFS_IRQ_MASK);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // ----------------------------------------------------------------------
  // Line monitor
  // ----------------------------------------------------------------------
  logic [1:0] bus_line_levels;
  logic       j_to_k;

  uhpc_line_mon u_line_mon (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .usb_dp          (usb_dp),
    .usb_dm          (usb_dm),
    .bus_line_levels (bus_line_levels),
    .j_to_k          (j_to_k)
  );

  // ----------------------------------------------------------------------
  // Schedule pointer
  // ----------------------------------------------------------------------
  logic [31:0] next_queue_head_pointer_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      next_queue_head_pointer_q <= `UHPC_PTR_RST;
    end else if (hc_reset) begin
      next_queue_head_pointer_q <= `UHPC_PTR_RST;
    end else if (wr_ptr) begin
      next_queue_head_pointer_q <= hwdata & `UHPC_PTR_MASK;  // see [R1]
    end
  end

  // ----------------------------------------------------------------------
  // Port state
  // ----------------------------------------------------------------------
  logic            conn_q;
  logic            conn_chg_q;
  logic            en_q;
  logic            forced_port_wakeup_q;
  logic            port_suspend_state_q;
  logic            port_bus_reset_q;
  logic            test_forced_port_enable_q;
  uhpc_port_mode_t mode;
  logic            conn_evt;
  logic            rst_end;
  logic            resume_end;
  logic            resume_det;

  always_comb begin
    if (!en_q) begin
      mode = UHPC_PORT_DISABLED;  // see [R13]
    end else if (port_suspend_state_q) begin
      mode = UHPC_PORT_SUSPENDED;  // see [R13]
    end else begin
      mode = UHPC_PORT_ENABLED;  // see [R13]
    end
  end

  assign conn_evt   = conn_q != dev_attached;
  assign rst_end    = port_bus_reset_q && wr_port && !hwdata[`UHPC_PSC_RST];
  assign resume_end = forced_port_wakeup_q && wr_port && !hwdata[`UHPC_PSC_RESUME];
  assign resume_det = j_to_k && (mode == UHPC_PORT_SUSPENDED);  // see [R15]

  // Connect status and its change flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conn_q     <= 1'b0;  // see [R3]
      conn_chg_q <= 1'b0;
    end else if (hc_reset) begin
      conn_q     <= 1'b0;  // see [R2]
      conn_chg_q <= 1'b0;  // see [R2]
    end else begin
      conn_q <= dev_attached;  // see [R5]
      if (conn_evt) begin
        conn_chg_q <= 1'b1;  // see [R5]
      end else if (wr_port && hwdata[`UHPC_PSC_CONN_CHG]) begin
        conn_chg_q <= 1'b0;
      end
    end
  end

  // Port enable, set by a test force write or at the end of bus reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= 1'b0;  // see [R3]
    end else if (hc_reset) begin
      en_q <= 1'b0;  // see [R2]
    end else if (wr_port && hwdata[`UHPC_PSC_TFORCE]) begin
      en_q <= 1'b1;  // see [R6]
    end else if (rst_end && conn_q) begin
      en_q <= 1'b1;  // see [R10]
    end else if ((conn_q && !dev_attached) || (wr_port && !hwdata[`UHPC_PSC_EN])) begin
      en_q <= 1'b0;
    end else if (!port_bus_reset_q && wr_port && hwdata[`UHPC_PSC_RST]) begin
      en_q <= 1'b0;
    end
  end

  // Bus reset and test force
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_bus_reset_q          <= 1'b0;
      test_forced_port_enable_q <= 1'b0;
    end else if (hc_reset) begin
      port_bus_reset_q          <= 1'b0;  // see [R2]
      test_forced_port_enable_q <= 1'b0;  // see [R2]
    end else if (wr_port) begin
      port_bus_reset_q          <= hwdata[`UHPC_PSC_RST];  // see [R9], [R10]
      test_forced_port_enable_q <= hwdata[`UHPC_PSC_TFORCE];  // see [R6]
    end
  end

  // Suspend: entered by a software write, left at resume end, port disable or bus reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_suspend_state_q <= 1'b0;
    end else if (hc_reset) begin
      port_suspend_state_q <= 1'b0;  // see [R2]
    end else if (!en_q || port_bus_reset_q || resume_end) begin
      port_suspend_state_q <= 1'b0;
    end else if (wr_port && hwdata[`UHPC_PSC_SUSP]) begin
      port_suspend_state_q <= 1'b1;  // see [R16]
    end
  end

  // Resume: detected on the line or driven by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      forced_port_wakeup_q <= 1'b0;
    end else if (hc_reset) begin
      forced_port_wakeup_q <= 1'b0;  // see [R2]
    end else if (resume_det) begin
      forced_port_wakeup_q <= 1'b1;  // see [R17]
    end else if (wr_port && en_q) begin
      forced_port_wakeup_q <= hwdata[`UHPC_PSC_RESUME];
    end else if (!en_q) begin
      forced_port_wakeup_q <= 1'b0;
    end
  end

  assign port_enabled    = en_q;
  assign port_suspended  = mode == UHPC_PORT_SUSPENDED;
  assign bus_reset_drive = port_bus_reset_q;
  assign resume_drive    = forced_port_wakeup_q;
  assign hs_test_mode    = test_forced_port_enable_q;
  assign tx_permit       = (mode == UHPC_PORT_ENABLED) || port_bus_reset_q;  // see [R14]

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  logic [`UHPC_IRQ_W-1:0] irq_stat_q;
  logic [`UHPC_IRQ_W-1:0] irq_mask_q;
  logic [`UHPC_IRQ_W-1:0] irq_set;

  assign irq_set = {rst_end, resume_det, conn_evt};  // see [R17]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_q <= `UHPC_IRQ_RST;
    end else if (hc_reset) begin
      irq_stat_q <= `UHPC_IRQ_RST;
    end else begin
      irq_stat_q <= irq_set | (irq_stat_q & ~(wr_stat ? hwdata[`UHPC_IRQ_W-1:0] : '0));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_q <= `UHPC_IRQ_RST;
    end else if (wr_mask) begin
      irq_mask_q <= hwdata[`UHPC_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [31:0] port_word;

  always_comb begin
    port_word                                        = '0;  // see [R18]
    port_word[`UHPC_PSC_CONN]                        = conn_q;
    port_word[`UHPC_PSC_CONN_CHG]                    = conn_chg_q;
    port_word[`UHPC_PSC_EN]                          = en_q;
    port_word[`UHPC_PSC_RESUME]                      = forced_port_wakeup_q;
    port_word[`UHPC_PSC_SUSP]                        = port_suspend_state_q;
    port_word[`UHPC_PSC_RST]                         = port_bus_reset_q;  // see [R9]
    port_word[`UHPC_PSC_LINE_HI:`UHPC_PSC_LINE_LO]   = bus_line_levels;  // see [R8]
    port_word[`UHPC_PSC_TFORCE]                      = test_forced_port_enable_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (addr_phase && !hwrite) begin
      if (haddr[7:0] == `UHPC_OFS_ASYNC_PTR) begin
        hrdata_q <= next_queue_head_pointer_q;
      end else if (haddr[7:0] == `UHPC_OFS_PORT_SC) begin
        hrdata_q <= port_word;
      end else if (haddr[7:0] == `UHPC_OFS_IRQ_STAT) begin
        hrdata_q <= {29'h0, irq_stat_q};
      end else if (haddr[7:0] == `UHPC_OFS_IRQ_MASK) begin
        hrdata_q <= {29'h0, irq_mask_q};
      end else begin
        hrdata_q <= '0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_ptr_low_zero: assert property (@(posedge hclk) disable iff (!hresetn)  // see [R1]
    wr_ptr && !hc_reset |=> next_queue_head_pointer_q == ($past(hwdata) & 32'hFFFF_FFE0))
    else $error("pointer does not keep bits 31:5 only");

  a_hc_reset_clears: assert property (@(posedge hclk) disable iff (!hresetn)  // see [R2]
    hc_reset |=> !en_q && !conn_q && !port_bus_reset_q && !conn_chg_q)
    else $error("controller reset left port state");

  a_attach_flags: assert property (@(posedge hclk) disable iff (!hresetn)  // see [R5]
    !hc_reset && !conn_q && dev_attached |=> conn_q && conn_chg_q)
    else $error("attach not reported");

  a_tforce_enables: assert property (@(posedge hclk) disable iff (!hresetn)  // see [R6]
    !hc_reset && wr_port && hwdata[16] |=> port_enabled && hs_test_mode)
    else $error("test force did not enable port");

  a_reset_reads_one: assert property (@(posedge hclk) disable iff (!hresetn)  // see [R9]
    !hc_reset && wr_port && hwdata[8] && !hwdata[16]
      |=> bus_reset_drive && port_word[8] && !port_enabled)
    else $error("bus reset not started");

  a_reset_end_en: assert property (@(posedge hclk) disable iff (!hresetn)  // see [R10]
    !hc_reset && rst_end && conn_q && !hwdata[16] |=> !bus_reset_drive && port_enabled)
    else $error("bus reset end did not enable port");

  a_susp_blocks_tx: assert property (@(posedge hclk) disable iff (!hresetn)  // see [R14]
    port_suspended && !bus_reset_drive |-> !tx_permit)
    else $error("data allowed while suspended");

  a_susp_zero_ign: assert property (@(posedge hclk) disable iff (!hresetn)  // see [R16]
    port_suspended && wr_port && !hwdata[7] && hwdata[2] && !hwdata[8] && !resume_end
      && !hc_reset && dev_attached |=> port_suspended)
    else $error("suspend left by writing zero");

  a_resume_sets: assert property (@(posedge hclk) disable iff (!hresetn)  // see [R17]
    !hc_reset && resume_det |=> resume_drive && irq_stat_q[1])
    else $error("resume detect did not set flags");

  a_state_decode: assert property (@(posedge hclk) disable iff (!hresetn)  // see [R13]
    !port_enabled |-> !port_suspended && (!tx_permit || bus_reset_drive))
    else $error("disabled port not decoded as disabled");

  a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)  // see [R5]
    |(irq_set & irq_mask_q) && !wr_mask && !hc_reset |=> irq)
    else $error("interrupt level wrong");

  c_resume_seen: cover property (@(posedge hclk) disable iff (!hresetn) resume_det);
  c_reset_done: cover property (@(posedge hclk) disable iff (!hresetn) rst_end && conn_q);
  c_suspend_in: cover property (@(posedge hclk) disable iff (!hresetn) $rose(port_suspended));

endmodule : uhpc_port_ctrl
`default_nettype wire

/* File: uhpc_dev_model.sv */
// Behavioural USB peripheral on the downstream port
`timescale 1ns/1ps
`default_nettype none

module uhpc_dev_model (
  // Clock
  input  wire logic hclk,
  // Bench control
  input  wire logic attach_req,
  input  wire logic resume_req,
  // Bus lines
  output logic      usb_dp,
  output logic      usb_dm,
  output logic      dev_attached
);
  initial begin
    {usb_dp, usb_dm, dev_attached} = 3'h0;
  end

  always @(posedge hclk) begin
    dev_attached <= attach_req;
    if (!attach_req) begin
      {usb_dp, usb_dm} <= 2'h0;  // Host pull-downs give SE0
    end else if (resume_req) begin
      {usb_dp, usb_dm} <= 2'h1;
    end else begin
      {usb_dp, usb_dm} <= 2'h2;
    end
  end
endmodule : uhpc_dev_model

`default_nettype wire

/* File: tb.sv */
// Self-checking testbench of the host port block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import uhpc_pkg::*;
  logic        hclk, hresetn, hc_reset, hsel, hwrite, attach_req, resume_req;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire logic   hready;
  logic        hreadyout, hresp, usb_dp, usb_dm, dev_attached, port_enabled;
  logic        port_suspended, bus_reset_drive, resume_drive, hs_test_mode, tx_permit, irq;
  logic [31:0] hrdata;
  int          n_fail, comparisons, i;
  int unsigned seed, m_ptr;
  assign hready = hreadyout;

  uhpc_port_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hc_reset(hc_reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .usb_dp(usb_dp),
    .usb_dm(usb_dm), .dev_attached(dev_attached), .port_enabled(port_enabled),
    .port_suspended(port_suspended), .bus_reset_drive(bus_reset_drive),
    .resume_drive(resume_drive), .hs_test_mode(hs_test_mode), .tx_permit(tx_permit), .irq(irq));

  uhpc_dev_model dev_u (.hclk(hclk), .attach_req(attach_req), .resume_req(resume_req),
    .usb_dp(usb_dp), .usb_dm(usb_dm), .dev_attached(dev_attached));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic wrap_up();
    $display("counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 16);
    if (hready !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
  endtask : wait_rdy

  // One single AHB-Lite word transfer, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    @(posedge hclk);
  endtask : xfer

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m);
    xfer(1'b0, a, 32'h0);
    chk(nm, e & m, rd & m);
  endtask : rdc

  task automatic pin(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : pin

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    wrap_up();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {hresetn, hc_reset, hsel, hwrite, attach_req, resume_req} = 6'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    n_fail = 0;
    comparisons = 0;
    seed = 4243;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("ptr_rst", 8'h28, 32'h0, 32'hFFFF_FFFF);
    rdc("psc_rst", 8'h30, 32'h0, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h3C, 32'h0, 32'hFFFF_FFFF);
    pin("port_enabled", 1'b0, port_enabled);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      m_ptr = xs();
      xfer(1'b1, 8'h28, m_ptr);
      m_ptr = m_ptr & 32'hFFFF_FFE0;
      rdc("ptr", 8'h28, m_ptr, 32'hFFFF_FFFF);
    end
    $display("test pointer done");
    attach_req <= 1'b1;
    repeat (4) @(posedge hclk);
    rdc("psc_attach", 8'h30, 32'h803, 32'hFFFF_FFFF);
    pin("irq_masked", 1'b0, irq);
    xfer(1'b1, 8'h44, 32'h1);
    pin("irq_unmasked", 1'b1, irq);
    xfer(1'b1, 8'h40, 32'h1);
    pin("irq_cleared", 1'b0, irq);
    $display("test attach done");
    xfer(1'b1, 8'h44, 32'h7);
    xfer(1'b1, 8'h30, 32'h102);
    rdc("psc_busrst", 8'h30, 32'h901, 32'hFFFF_FFFF);
    pin("bus_reset_drive", 1'b1, bus_reset_drive);
    pin("tx_permit_rst", 1'b1, tx_permit);
    repeat (8) @(posedge hclk);
    xfer(1'b1, 8'h30, 32'h0);
    rdc("psc_rst_end", 8'h30, 32'h805, 32'hFFFF_FFFF);
    rdc("irq_rst_done", 8'h40, 32'h4, 32'hFFFF_FFFF);
    pin("irq_rst", 1'b1, irq);
    xfer(1'b1, 8'h40, 32'h4);
    $display("test bus reset done");
    xfer(1'b1, 8'h30, 32'h84);
    rdc("psc_susp", 8'h30, 32'h885, 32'hFFFF_FFFF);
    pin("port_suspended", 1'b1, port_suspended);
    pin("tx_permit_susp", 1'b0, tx_permit);
    xfer(1'b1, 8'h30, 32'h4);
    rdc("psc_susp0", 8'h30, 32'h885, 32'hFFFF_FFFF);
    resume_req <= 1'b1;
    for (i = 0; i < 20 && resume_drive !== 1'b1; i++) @(posedge hclk);
    if (resume_drive !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
    pin("resume_drive", 1'b1, resume_drive);
    rdc("psc_resume", 8'h30, 32'h4C5, 32'hFFFF_FFFF);
    rdc("irq_pcd", 8'h40, 32'h2, 32'hFFFF_FFFF);
    resume_req <= 1'b0;
    xfer(1'b1, 8'h40, 32'h2);
    xfer(1'b1, 8'h30, 32'h4);
    rdc("psc_woken", 8'h30, 32'h805, 32'hFFFF_FFFF);
    pin("suspend_left", 1'b0, port_suspended);
    pin("tx_permit_en", 1'b1, tx_permit);
    xfer(1'b1, 8'h30, 32'h84);
    xfer(1'b1, 8'h30, 32'h80);
    rdc("psc_dis", 8'h30, 32'h801, 32'hFFFF_FFFF);
    pin("port_dis", 1'b0, port_enabled);
    $display("test suspend done");
    xfer(1'b1, 8'h30, 32'h1_0000);
    rdc("psc_tforce", 8'h30, 32'h1_0805, 32'hFFFF_FFFF);
    pin("hs_test_mode", 1'b1, hs_test_mode);
    pin("tx_permit_tf", 1'b1, tx_permit);
    xfer(1'b1, 8'h30, 32'hFFFF_F23F);
    rdc("psc_resv", 8'h30, 32'h1_0805, 32'hFFFF_FFFF);
    $display("test force done");
    hc_reset <= 1'b1;
    @(posedge hclk);
    hc_reset <= 1'b0;
    @(posedge hclk);
    rdc("ptr_hcrst", 8'h28, 32'h0, 32'hFFFF_FFFF);
    rdc("psc_hcrst", 8'h30, 32'h0, 32'h0001_01C4);
    rdc("mask_kept", 8'h44, 32'h7, 32'hFFFF_FFFF);
    pin("hs_test_off", 1'b0, hs_test_mode);
    $display("test controller reset done");
    wrap_up();
  end
endmodule : tb

`default_nettype wire
